/* File: inc/mtm_cfg.svh */
/*
 * Register offsets, field positions and reset values of the trigger,
 * marker and clock control block. Assumes byte addresses on a 32-bit APB.
 */
`ifndef MTM_CFG_SVH
`define MTM_CFG_SVH

`define MTM_OFF_CTRL 8'h00
`define MTM_OFF_STAT 8'h04
`define MTM_OFF_SLEN 8'h08
`define MTM_OFF_EDLY 8'h0c
`define MTM_OFF_INH 8'h10
`define MTM_OFF_SDIV 8'h14
`define MTM_OFF_MULT 8'h18
`define MTM_OFF_BPS 8'h1c
`define MTM_OFF_DMIN 8'h20
`define MTM_OFF_DMAX 8'h24
`define MTM_OFF_CMD 8'h28
`define MTM_OFF_MK 8'h40
`define MTM_MK_STRIDE 8'h20

`define MTM_MK_MODE 3'h0
`define MTM_MK_DIV 3'h1
`define MTM_MK_PLO 3'h2
`define MTM_MK_PHI 3'h3
`define MTM_MK_LEN 3'h4
`define MTM_MK_ON 3'h5
`define MTM_MK_OFF 3'h6
`define MTM_MK_DLY 3'h7

`define MTM_CTRL_MODE 2:0
`define MTM_CTRL_EXT 3
`define MTM_CTRL_SYNC 4
`define MTM_CTRL_FALL 5
`define MTM_CTRL_CKEXT 6
`define MTM_CTRL_CKMODE 8:7
`define MTM_CTRL_FIX 9
`define MTM_CTRL_EN 10
`define MTM_CTRL_RST 32'h0000_0010

`define MTM_CMD_ARM 0
`define MTM_CMD_EXEC 1
`define MTM_STAT_RUN 0
`define MTM_STAT_REF 1
`define MTM_STAT_WAIT 2

`define MTM_PAT_MAX 7'h40
`define MTM_LATENCY 16

`endif

/* File: inc/mtm_pkg.sv */
/*
 * Types of the trigger, marker and clock control block.
 * Assumes mtm_cfg.svh holds the numbers.
 */
package mtm_pkg;

  typedef enum logic [2:0] {
    MTM_TM_AUTO = 3'h0,
    MTM_TM_RETRIG = 3'h1,
    MTM_TM_ARM_AUTO = 3'h2,
    MTM_TM_ARM_RETRIG = 3'h3,
    MTM_TM_SINGLE = 3'h4
  } mtm_trig_mode_type;

  typedef enum logic [1:0] {
    MTM_CK_SYMBOL = 2'h0,
    MTM_CK_MULTI = 2'h1,
    MTM_CK_BIT = 2'h2
  } mtm_clk_mode_type;

  typedef enum logic [1:0] {
    MTM_MK_LIST = 2'h0,
    MTM_MK_PULSE = 2'h1,
    MTM_MK_PATTERN = 2'h2,
    MTM_MK_RATIO = 2'h3
  } mtm_mk_mode_type;

  typedef enum logic [2:0] {
    MTM_ST_STOP = 3'b001,
    MTM_ST_WAIT = 3'b010,
    MTM_ST_RUN = 3'b100
  } mtm_state_type;

  typedef struct packed {
    mtm_mk_mode_type mode;
    logic [15:0] div;
    logic [63:0] pat;
    logic [6:0] len;
    logic [15:0] on_t;
    logic [15:0] off_t;
    logic [15:0] dly;
  } mtm_mk_cfg_type;

endpackage

/* File: rtl/mtm_top.sv */
/*
 * Trigger, marker and clock control of a digital modulation source,
 * with an APB register slave. Assumes ext_trig and ext_clk are
 * asynchronous pins, control_list_marker comes from pclk logic.
 */
// The APB interface to the registers and the register addresses were decided locally.
// Function
// - Single mode runs programmed symbols then stops
// - Running or stopped status reported always
// - Arm stops running armed modes only
// - After arm, next trigger restarts generation
// - Manual trigger needs internal source, not auto
// - External trigger on active input edge
// - Sync on: start at trigger, blank latency
// - Sync off: output after latency from start
// - External trigger delayed by programmed symbols
// - Inhibit further external triggers for symbols
// - Retrigger restarts generation from the beginning
// - List marker follows control list trace
// - Pulse marker: sample rate over divider
// - Pattern marker repeats up to 64 bits
// - Ratio marker: programmed high, low phases
// - Each marker delayed independently in symbols
// - Live delay changes, optional range restriction
// - Symbol timing from internal or external clock
// - Multiple clock divides; refused with ext data
// - Bit clock derives symbol; refused with ext data
`timescale 1ns/1ns
`include "mtm_cfg.svh"

module mtm_top #(
  parameter int NM = 2,
  parameter int LATENCY = `MTM_LATENCY
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_trig,
  input wire logic ext_clk,
  input wire logic ext_data_sel,
  input wire logic [NM-1:0] control_list_marker,
  output logic sym_tick,
  output logic running,
  output logic sig_valid,
  output logic [15:0] sym_pos,
  output logic [NM-1:0] marker
);

  logic [31:0] ctrl_reg;
  logic [15:0] slen_reg, edly_reg, inh_reg, sdiv_reg, mult_reg, bps_reg;
  logic [15:0] dmin_reg, dmax_reg;
  logic refused_reg;
  mtm_pkg::mtm_mk_cfg_type mk_reg [NM];
  mtm_pkg::mtm_state_type state_reg;
  logic [31:0] rd_next;
  logic acc, wr, unmapped;
  logic arm_cmd, exec_cmd;
  mtm_pkg::mtm_trig_mode_type tmode;

  // Marker window: index or -1
  function automatic int mk_sel(input logic [7:0] a);
    int i;
    i = -1;
    if (a >= `MTM_OFF_MK && a < `MTM_OFF_MK + 8'(NM) * `MTM_MK_STRIDE) begin
      i = int'((a - `MTM_OFF_MK) >> 5);
    end
    return i;
  endfunction

  function automatic logic [2:0] mk_fld(input logic [7:0] a);
    return a[4:2];
  endfunction

  assign tmode = mtm_pkg::mtm_trig_mode_type'(ctrl_reg[`MTM_CTRL_MODE]);
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign arm_cmd = wr && paddr == `MTM_OFF_CMD && pwdata[`MTM_CMD_ARM];
  assign exec_cmd = wr && paddr == `MTM_OFF_CMD && pwdata[`MTM_CMD_EXEC];

  // APB: one wait state, then a one-cycle pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_next : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & unmapped;
    end
  end

  always_comb begin
    int m;
    m = mk_sel(paddr);
    rd_next = 32'h0000_0000;
    unmapped = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      unmapped = 1'b1;
    end else if (m >= 0) begin
      case (mk_fld(paddr))
        `MTM_MK_MODE: rd_next = 32'(mk_reg[m].mode);
        `MTM_MK_DIV: rd_next = 32'(mk_reg[m].div);
        `MTM_MK_PLO: rd_next = mk_reg[m].pat[31:0];
        `MTM_MK_PHI: rd_next = mk_reg[m].pat[63:32];
        `MTM_MK_LEN: rd_next = 32'(mk_reg[m].len);
        `MTM_MK_ON: rd_next = 32'(mk_reg[m].on_t);
        `MTM_MK_OFF: rd_next = 32'(mk_reg[m].off_t);
        default: rd_next = 32'(mk_reg[m].dly);
      endcase
    end else begin
      case (paddr)
        `MTM_OFF_CTRL: rd_next = ctrl_reg;
        `MTM_OFF_STAT: rd_next = {29'h0, state_reg == mtm_pkg::MTM_ST_WAIT,
          refused_reg, state_reg != mtm_pkg::MTM_ST_STOP};
        `MTM_OFF_SLEN: rd_next = 32'(slen_reg);
        `MTM_OFF_EDLY: rd_next = 32'(edly_reg);
        `MTM_OFF_INH: rd_next = 32'(inh_reg);
        `MTM_OFF_SDIV: rd_next = 32'(sdiv_reg);
        `MTM_OFF_MULT: rd_next = 32'(mult_reg);
        `MTM_OFF_BPS: rd_next = 32'(bps_reg);
        `MTM_OFF_DMIN: rd_next = 32'(dmin_reg);
        `MTM_OFF_DMAX: rd_next = 32'(dmax_reg);
        `MTM_OFF_CMD: rd_next = 32'h0000_0000;
        default: unmapped = 1'b1;
      endcase
    end
  end

  // Global configuration
  always_ff @(posedge pclk or negedge presetn) begin
    logic refuse;
    refuse = 1'b0;
    if (!presetn) begin
      ctrl_reg <= `MTM_CTRL_RST;
      slen_reg <= 16'h0001;
      edly_reg <= 16'h0000;
      inh_reg <= 16'h0000;
      sdiv_reg <= 16'h0001;
      mult_reg <= 16'h0001;
      bps_reg <= 16'h0001;
      dmin_reg <= 16'h0000;
      dmax_reg <= 16'hffff;
      refused_reg <= 1'b0;
    end else begin
      if (wr && paddr == `MTM_OFF_CTRL) begin
        refuse = ext_data_sel && pwdata[`MTM_CTRL_CKMODE] != 2'(mtm_pkg::MTM_CK_SYMBOL);
        ctrl_reg <= {21'h0, pwdata[10:9],
          refuse ? ctrl_reg[`MTM_CTRL_CKMODE] : pwdata[`MTM_CTRL_CKMODE], pwdata[6:0]};
      end
      if (wr && paddr == `MTM_OFF_SLEN) slen_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_EDLY) edly_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_INH) inh_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_SDIV) sdiv_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_MULT) mult_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_BPS) bps_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_DMIN) dmin_reg <= pwdata[15:0];
      if (wr && paddr == `MTM_OFF_DMAX) dmax_reg <= pwdata[15:0];
      // Set wins over the write-one clear
      if (refuse) begin
        refused_reg <= 1'b1;
      end else if (wr && paddr == `MTM_OFF_STAT && pwdata[`MTM_STAT_REF]) begin
        refused_reg <= 1'b0;
      end
    end
  end

  // Marker configuration
  always_ff @(posedge pclk or negedge presetn) begin
    int m;
    m = mk_sel(paddr);
    if (!presetn) begin
      for (int i = 0; i < NM; i++) begin
        mk_reg[i] <= '{mode: mtm_pkg::MTM_MK_LIST, div: 16'h0002, pat: 64'h0,
          len: `MTM_PAT_MAX, on_t: 16'h0001, off_t: 16'h0001, dly: 16'h0000};
      end
    end else if (wr && m >= 0) begin
      case (mk_fld(paddr))
        `MTM_MK_MODE: mk_reg[m].mode <= mtm_pkg::mtm_mk_mode_type'(pwdata[1:0]);
        `MTM_MK_DIV: mk_reg[m].div <= pwdata[15:0];
        `MTM_MK_PLO: mk_reg[m].pat[31:0] <= pwdata;
        `MTM_MK_PHI: mk_reg[m].pat[63:32] <= pwdata;
        `MTM_MK_LEN: begin
          if (pwdata[6:0] != 7'h0 && pwdata[6:0] <= `MTM_PAT_MAX) begin
            mk_reg[m].len <= pwdata[6:0];
          end
        end
        `MTM_MK_ON: mk_reg[m].on_t <= pwdata[15:0];
        `MTM_MK_OFF: mk_reg[m].off_t <= pwdata[15:0];
        default: begin
          // Out-of-range delays dropped while restricted
          if (!ctrl_reg[`MTM_CTRL_FIX] ||
              (pwdata[15:0] >= dmin_reg && pwdata[15:0] <= dmax_reg)) begin
            mk_reg[m].dly <= pwdata[15:0];
          end
        end
      endcase
    end
  end

  // Pin synchronisers
  logic [2:0] trig_sync_reg, clk_sync_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sync_reg <= 3'h0;
      clk_sync_reg <= 3'h0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], ext_trig};
      clk_sync_reg <= {clk_sync_reg[1:0], ext_clk};
    end
  end

  logic trig_edge, clk_edge;
  assign trig_edge = ctrl_reg[`MTM_CTRL_FALL] ?
    (~trig_sync_reg[1] & trig_sync_reg[2]) : (trig_sync_reg[1] & ~trig_sync_reg[2]);
  assign clk_edge = clk_sync_reg[1] & ~clk_sync_reg[2];

  // Symbol tick from internal divider or external clock
  logic [15:0] ck_cnt_reg, ck_div;
  logic tick;
  always_comb begin
    if (!ctrl_reg[`MTM_CTRL_CKEXT]) begin
      ck_div = sdiv_reg;
    end else begin
      case (mtm_pkg::mtm_clk_mode_type'(ctrl_reg[`MTM_CTRL_CKMODE]))
        mtm_pkg::MTM_CK_MULTI: ck_div = mult_reg;
        mtm_pkg::MTM_CK_BIT: ck_div = bps_reg;
        default: ck_div = 16'h0001;
      endcase
    end
    if (ck_div == 16'h0) ck_div = 16'h0001;
  end
  assign tick = (!ctrl_reg[`MTM_CTRL_CKEXT] || clk_edge) && ck_cnt_reg >= ck_div - 16'h1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_cnt_reg <= 16'h0;
      sym_tick <= 1'b0;
    end else begin
      sym_tick <= tick;
      if (tick) begin
        ck_cnt_reg <= 16'h0;
      end else if (!ctrl_reg[`MTM_CTRL_CKEXT] || clk_edge) begin
        ck_cnt_reg <= ck_cnt_reg + 16'h1;
      end
    end
  end

  // External trigger delay and inhibit, in symbols
  logic [15:0] dly_cnt_reg, inh_cnt_reg;
  logic dly_act_reg, ext_take, ext_fire, int_fire, trig;
  assign ext_take = ctrl_reg[`MTM_CTRL_EXT] && trig_edge && inh_cnt_reg == 16'h0;
  assign ext_fire = dly_act_reg && dly_cnt_reg == 16'h0;
  assign int_fire = exec_cmd && !ctrl_reg[`MTM_CTRL_EXT] && tmode != mtm_pkg::MTM_TM_AUTO;
  assign trig = int_fire | (ext_fire & ctrl_reg[`MTM_CTRL_EXT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt_reg <= 16'h0;
      inh_cnt_reg <= 16'h0;
      dly_act_reg <= 1'b0;
    end else begin
      if (ext_take) begin
        inh_cnt_reg <= inh_reg;
        dly_cnt_reg <= edly_reg;
        dly_act_reg <= 1'b1;
      end else begin
        if (tick && inh_cnt_reg != 16'h0) inh_cnt_reg <= inh_cnt_reg - 16'h1;
        if (ext_fire) begin
          dly_act_reg <= 1'b0;
        end else if (tick && dly_cnt_reg != 16'h0) begin
          dly_cnt_reg <= dly_cnt_reg - 16'h1;
        end
      end
    end
  end

  // Generation sequence
  logic [15:0] lat_cnt_reg, blank_cnt_reg;
  logic start, restart_ok, arm_ok, done, go_run;
  assign restart_ok = tmode == mtm_pkg::MTM_TM_RETRIG || tmode == mtm_pkg::MTM_TM_ARM_RETRIG ||
    tmode == mtm_pkg::MTM_TM_SINGLE;
  assign arm_ok = arm_cmd && state_reg == mtm_pkg::MTM_ST_RUN &&
    (tmode == mtm_pkg::MTM_TM_ARM_AUTO || tmode == mtm_pkg::MTM_TM_ARM_RETRIG);
  assign done = tmode == mtm_pkg::MTM_TM_SINGLE && tick && sym_pos >= slen_reg - 16'h1;
  always_comb begin
    start = 1'b0;
    case (state_reg)
      mtm_pkg::MTM_ST_STOP: start = trig || tmode == mtm_pkg::MTM_TM_AUTO ||
        tmode == mtm_pkg::MTM_TM_RETRIG;
      mtm_pkg::MTM_ST_WAIT: start = trig && restart_ok;
      mtm_pkg::MTM_ST_RUN: start = trig && restart_ok && !arm_ok;
      default: start = 1'b0;
    endcase
    start = start & ctrl_reg[`MTM_CTRL_EN];
  end
  assign go_run = (start && ctrl_reg[`MTM_CTRL_SYNC]) ||
    (!start && state_reg == mtm_pkg::MTM_ST_WAIT && lat_cnt_reg == 16'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= mtm_pkg::MTM_ST_STOP;
      lat_cnt_reg <= 16'h0;
      blank_cnt_reg <= 16'h0;
      sym_pos <= 16'h0;
    end else if (!ctrl_reg[`MTM_CTRL_EN]) begin
      state_reg <= mtm_pkg::MTM_ST_STOP;
      blank_cnt_reg <= 16'h0;
    end else if (start && ctrl_reg[`MTM_CTRL_SYNC]) begin
      state_reg <= mtm_pkg::MTM_ST_RUN;
      sym_pos <= 16'h0;
      blank_cnt_reg <= 16'(LATENCY);
    end else if (start) begin
      state_reg <= mtm_pkg::MTM_ST_WAIT;
      lat_cnt_reg <= 16'(LATENCY - 1);
      blank_cnt_reg <= 16'h0;
    end else begin
      case (state_reg)
        mtm_pkg::MTM_ST_WAIT: begin
          if (lat_cnt_reg == 16'h0) begin
            state_reg <= mtm_pkg::MTM_ST_RUN;
            sym_pos <= 16'h0;
          end else begin
            lat_cnt_reg <= lat_cnt_reg - 16'h1;
          end
        end
        mtm_pkg::MTM_ST_RUN: begin
          if (arm_ok || done) begin
            state_reg <= mtm_pkg::MTM_ST_STOP;
          end else if (tick) begin
            sym_pos <= sym_pos + 16'h1;
          end
          // Samples inside the latency are dropped
          if (blank_cnt_reg != 16'h0) blank_cnt_reg <= blank_cnt_reg - 16'h1;
        end
        default: state_reg <= mtm_pkg::MTM_ST_STOP;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running <= 1'b0;
      sig_valid <= 1'b0;
    end else begin
      running <= state_reg != mtm_pkg::MTM_ST_STOP;
      sig_valid <= state_reg == mtm_pkg::MTM_ST_RUN && blank_cnt_reg == 16'h0;
    end
  end

  // Marker generators, gated by per-marker delay
  logic [15:0] mk_cnt_reg [NM];
  logic [6:0] mk_idx_reg [NM];
  always_ff @(posedge pclk or negedge presetn) begin
    logic gate;
    gate = 1'b0;
    if (!presetn) begin
      for (int i = 0; i < NM; i++) begin
        mk_cnt_reg[i] <= 16'h0;
        mk_idx_reg[i] <= 7'h0;
      end
      marker <= '0;
    end else begin
      for (int i = 0; i < NM; i++) begin
        // Delay is read live, so changes need no restart
        gate = state_reg == mtm_pkg::MTM_ST_RUN && sym_pos >= mk_reg[i].dly;
        if (go_run || !gate) begin
          mk_cnt_reg[i] <= 16'h0;
          mk_idx_reg[i] <= 7'h0;
          marker[i] <= 1'b0;
        end else begin
          case (mk_reg[i].mode)
            mtm_pkg::MTM_MK_LIST: marker[i] <= control_list_marker[i];
            mtm_pkg::MTM_MK_PULSE: begin
              // One sample per clock: period is div clocks
              marker[i] <= mk_cnt_reg[i] < (mk_reg[i].div >> 1);
              mk_cnt_reg[i] <= (mk_cnt_reg[i] + 16'h1 >= mk_reg[i].div) ?
                16'h0 : mk_cnt_reg[i] + 16'h1;
            end
            mtm_pkg::MTM_MK_PATTERN: begin
              marker[i] <= mk_reg[i].pat[6'(mk_idx_reg[i])];
              if (tick) begin
                mk_idx_reg[i] <= (mk_idx_reg[i] + 7'h1 >= mk_reg[i].len) ?
                  7'h0 : mk_idx_reg[i] + 7'h1;
              end
            end
            default: begin
              marker[i] <= mk_cnt_reg[i] < mk_reg[i].on_t;
              if (tick) begin
                mk_cnt_reg[i] <= (mk_cnt_reg[i] + 16'h1 >=
                  mk_reg[i].on_t + mk_reg[i].off_t) ? 16'h0 : mk_cnt_reg[i] + 16'h1;
              end
            end
          endcase
        end
      end
    end
  end

endmodule

/* File: tb/mtm_src_model.sv */
/*
 * Far-side model: external trigger source and external clock source.
 * Assumes the bench requests a trigger with a rising edge on fire.
 */
`timescale 1ns/1ns

module mtm_src_model (
  input wire logic pclk,
  input wire logic clk_on,
  input wire logic fire,
  input wire logic fall,
  output logic ext_trig,
  output logic ext_clk
);
  int cc = 0;
  int tc = 0;
  logic fire_q = 1'b0;
  always @(posedge pclk) begin
    cc <= clk_on ? (cc + 1) % 10 : 0;
    fire_q <= fire;
    if (fire && !fire_q) begin
      tc <= 6;
    end else if (tc > 0) begin
      tc <= tc - 1;
    end
  end
  // Clock parks low when unused; a tenth of pclk keeps it well inside the allowed rate
  assign ext_clk = clk_on && cc < 5;
  assign ext_trig = fall ^ (tc != 0);
endmodule

/* File: tb/mtm_top_props.sv */
/*
 * Port-level checker of the trigger, marker and clock control block.
 * Assumes the register map of mtm_cfg.svh and one wait state per APB transfer.
 */
`timescale 1ns/1ns
`include "mtm_cfg.svh"

module mtm_top_props #(
  parameter int NM = 2,
  parameter int LATENCY = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic running,
  input wire logic sig_valid,
  input wire logic [15:0] sym_pos,
  input wire logic [NM-1:0] marker
);
  localparam int L_LO = LATENCY - 1;
  localparam int L_HI = LATENCY + 3;
  logic [2:0] mode_reg;
  logic ext_reg;
  logic sync_reg;
  logic en_reg;
  logic wr;
  logic arm;
  logic exec;
  logic armed;
  assign wr = psel && penable && pready && pwrite;
  assign arm = wr && paddr == `MTM_OFF_CMD && pwdata[0];
  assign exec = wr && paddr == `MTM_OFF_CMD && pwdata[1];
  // Only armed and single modes wait for a trigger
  assign armed = mode_reg >= 3'h2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= 3'h0;
      ext_reg <= 1'b0;
      sync_reg <= 1'b1;
      en_reg <= 1'b0;
    end else if (wr && paddr == `MTM_OFF_CTRL) begin
      mode_reg <= pwdata[2:0];
      ext_reg <= pwdata[3];
      sync_reg <= pwdata[4];
      en_reg <= pwdata[10];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle into access");
  AST_APB_ERR: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not flagged");
  AST_VALID_RUN: assert property (sig_valid |-> running)
    else $error("valid output while stopped");
  AST_EXEC_START: assert property (exec && en_reg && !ext_reg && armed && !running
    |-> ##2 running)
    else $error("manual trigger did not start");
  AST_EXEC_REFUSE: assert property (exec && ext_reg && !running |=> !running [*4])
    else $error("manual trigger taken with external source");
  AST_ARM_STOP: assert property (arm && running && mode_reg[2:1] == 2'h1
    |-> ##[1:2] !running)
    else $error("arm did not stop");
  AST_ARM_KEEP: assert property (arm && running && mode_reg[2:1] == 2'h0 |=> running [*4])
    else $error("arm stopped a free running mode");
  AST_BLANK: assert property ($rose(running) && ext_reg && sync_reg && armed
    |-> !sig_valid [*8])
    else $error("output not blanked during latency");
  AST_LAT_END: assert property ($rose(running) && ext_reg && armed
    |-> ##[L_LO:L_HI] sig_valid)
    else $error("output not valid after latency");
  // sig_valid lags sym_pos by one cycle
  AST_SYNC_OFF_ZERO: assert property ($rose(sig_valid) && ext_reg && !sync_reg && armed
    |-> $past(sym_pos) == 16'h0000)
    else $error("unsynchronised output not from first symbol");
  AST_QUIET: assert property (!running && !$past(running) |-> marker == '0)
    else $error("marker active while stopped");
endmodule

bind mtm_top mtm_top_props #(.NM(NM), .LATENCY(LATENCY)) i_mtm_top_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pready(pready),
  .pslverr(pslverr),
  .running(running),
  .sig_valid(sig_valid),
  .sym_pos(sym_pos),
  .marker(marker)
);

/* File: tb/tb_top.sv */
/*
 * Self-checking bench of mtm_top: registers, triggers, markers, clocks.
 * Assumes mtm_cfg.svh offsets and the far-side model mtm_src_model.
 */
`timescale 1ns/1ns
`include "mtm_cfg.svh"

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, er, ext_trig, ext_clk, sym_tick, running, sig_valid;
  logic ext_data_sel = 1'b0;
  logic clk_on = 1'b0;
  logic fire = 1'b0;
  logic fall = 1'b0;
  logic [1:0] clm = 2'h0;
  logic [1:0] marker;
  logic [15:0] sym_pos, p;
  logic s0 [40];
  logic s1 [40];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int n, k, t, len;
  logic [31:0] pat;
  always #5 pclk = ~pclk;

  mtm_top #(.NM(2), .LATENCY(16)) i_mtm_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_trig(ext_trig), .ext_clk(ext_clk), .ext_data_sel(ext_data_sel),
    .control_list_marker(clm), .sym_tick(sym_tick), .running(running),
    .sig_valid(sig_valid), .sym_pos(sym_pos), .marker(marker));
  mtm_src_model i_mtm_src_model (.pclk(pclk), .clk_on(clk_on), .fire(fire), .fall(fall),
    .ext_trig(ext_trig), .ext_clk(ext_clk));

  task report_and_stop;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Held until pready is seen; trailing idle edge lets psel fall
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    j = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      j++;
    end while (pready !== 1'b1 && j < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (j >= 20) check(0, 1);
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task pulse;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input logic [2:0] m, input logic x, s, f);
    cw = {21'h0, 1'b1, 4'h0, f, s, x, m};
  endfunction
  function automatic logic [7:0] ma(input int m, input logic [2:0] r);
    ma = 8'(`MTM_OFF_MK + m * `MTM_MK_STRIDE + 4 * r);
  endfunction

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      $display("[ERR] %0t run too long", $time);
      report_and_stop;
    end
  end

  initial begin
    void'($urandom(28));
    wt(12);
    presetn <= 1'b1;
    wt(1);
    rchk(`MTM_OFF_CTRL, 32'hffffffff, `MTM_CTRL_RST);
    rchk(`MTM_OFF_SLEN, 32'hffffffff, 32'h1);
    xfer(1'b0, 8'h2c, 32'h0);
    check(er, 1);
    xfer(1'b0, 8'h05, 32'h0);
    check(er, 1);
    ext_data_sel <= 1'b1;
    for (int c = 1; c < 3; c++) begin
      wr(`MTM_OFF_CTRL, 32'h10 | (c << 7));
      rchk(`MTM_OFF_CTRL, 32'h180, 32'h0);
      rchk(`MTM_OFF_STAT, 32'h2, 32'h2);
      wr(`MTM_OFF_STAT, 32'h2);
    end
    ext_data_sel <= 1'b0;
    wr(`MTM_OFF_CTRL, 32'h90);
    rchk(`MTM_OFF_CTRL, 32'h180, 32'h80);
    $display("registers done");
    wr(`MTM_OFF_SDIV, 32'h4);
    wr(`MTM_OFF_CTRL, cw(3'h2, 1'b1, 1'b1, 1'b0));
    wt(10);
    check(running, 0);
    wr(`MTM_OFF_CMD, 32'h2);
    wt(4);
    check(running, 0);
    wr(`MTM_OFF_CTRL, cw(3'h2, 1'b0, 1'b1, 1'b0));
    for (int i = 0; i < 2; i++) begin
      wr(`MTM_OFF_CMD, 32'h2);
      wt(2);
      check(running, 1);
      wr(`MTM_OFF_CMD, 32'h1);
      wt(2);
      check(running, 0);
    end
    wr(`MTM_OFF_CTRL, cw(3'h1, 1'b0, 1'b1, 1'b0));
    wr(`MTM_OFF_CMD, 32'h1);
    wt(2);
    check(running, 1);
    $display("manual trigger done");
    n = 3 + $urandom % 6;
    wr(`MTM_OFF_CTRL, 32'h0);
    wr(`MTM_OFF_SLEN, n);
    wr(`MTM_OFF_CTRL, cw(3'h4, 1'b0, 1'b1, 1'b0));
    wr(`MTM_OFF_CMD, 32'h2);
    t = 0;
    for (k = 0; k < 400 && (t == 0 || running === 1'b1); k++) begin
      @(posedge pclk);
      if (running === 1'b1 && sym_tick === 1'b1) t++;
    end
    check(t, n);
    check(running, 0);
    $display("single done");
    wr(`MTM_OFF_EDLY, 32'h3);
    for (int f = 0; f < 2; f++) begin
      wr(`MTM_OFF_CTRL, 32'h0);
      fall <= f[0];
      wr(`MTM_OFF_CTRL, cw(3'h3, 1'b1, f[0], f[0]));
      wt(4);
      pulse;
      wt(10);
      check(running, 0);
      wt(40);
      check(running, 1);
      check(sig_valid, 1);
    end
    $display("external delay done");
    wr(`MTM_OFF_CTRL, 32'h0);
    fall <= 1'b0;
    wr(`MTM_OFF_EDLY, 32'h0);
    wr(`MTM_OFF_INH, 32'ha);
    wr(`MTM_OFF_CTRL, cw(3'h1, 1'b1, 1'b1, 1'b0));
    wt(60);
    pulse;
    wt(12);
    p = sym_pos;
    check(p < 16'h8, 1);
    pulse;
    wt(24);
    check(sym_pos >= p + 16'h4, 1);
    wt(40);
    pulse;
    wt(12);
    check(sym_pos < 16'h8, 1);
    $display("retrigger done");
    wr(`MTM_OFF_CTRL, 32'h0);
    wr(`MTM_OFF_SDIV, 32'h2);
    len = 3 + $urandom % 8;
    pat = $urandom;
    wr(ma(0, `MTM_MK_MODE), 32'h2);
    wr(ma(0, `MTM_MK_PLO), pat);
    wr(ma(0, `MTM_MK_LEN), len);
    wr(ma(1, `MTM_MK_MODE), 32'h3);
    wr(ma(1, `MTM_MK_ON), 32'h2);
    wr(ma(1, `MTM_MK_OFF), 32'h3);
    wr(`MTM_OFF_CTRL, cw(3'h0, 1'b0, 1'b1, 1'b0));
    wt(30);
    for (int i = 0; i < 40; i++) begin
      do @(posedge pclk); while (sym_tick !== 1'b1);
      s0[i] = marker[0];
      s1[i] = marker[1];
    end
    n = 0;
    t = 0;
    for (int i = 0; i < 30; i++) begin
      check(s0[i], s0[i + len]);
      check(s1[i], s1[i + 5]);
      if (i < len) n += s0[i];
      if (i < 5) t += s1[i];
    end
    check(n, $countones(pat & ((32'h1 << len) - 1)));
    check(t, 2);
    $display("pattern and ratio done");
    n = 2 + $urandom % 8;
    wr(ma(0, `MTM_MK_DIV), n);
    wr(ma(0, `MTM_MK_MODE), 32'h1);
    wr(ma(1, `MTM_MK_MODE), 32'h0);
    wt(10);
    k = 0;
    repeat (4 * n) begin
      @(posedge pclk);
      k += marker[0];
    end
    check(k, 4 * (n / 2));
    repeat (4) begin
      clm <= 2'($urandom);
      wt(6);
      check(marker[1], clm[1]);
    end
    wr(`MTM_OFF_DMIN, 32'h2);
    wr(`MTM_OFF_DMAX, 32'h14);
    wr(`MTM_OFF_CTRL, cw(3'h0, 1'b0, 1'b1, 1'b0) | 32'h200);
    wr(ma(0, `MTM_MK_DLY), 32'h1e);
    rchk(ma(0, `MTM_MK_DLY), 32'hffff, 32'h0);
    wr(ma(0, `MTM_MK_DLY), 32'h5);
    rchk(ma(0, `MTM_MK_DLY), 32'hffff, 32'h5);
    $display("pulse list delay done");
    wr(`MTM_OFF_MULT, 32'h2);
    wr(`MTM_OFF_BPS, 32'h4);
    for (int c = 0; c < 3; c++) begin
      wr(`MTM_OFF_CTRL, 32'h0);
      wr(`MTM_OFF_CTRL, cw(3'h0, 1'b0, 1'b1, 1'b0) | 32'h40 | (c << 7));
      // No ticks yet, so sym_pos stays below the marker delay
      repeat (4) begin
        @(posedge pclk);
        check(marker[0], 0);
      end
      clk_on <= 1'b1;
      wt(20);
      k = 0;
      repeat (200) begin
        @(posedge pclk);
        k += sym_tick;
      end
      clk_on <= 1'b0;
      check(k >= (20 >> c) - 1 && k <= (20 >> c) + 1, 1);
    end
    $display("external clock done");
    report_and_stop;
  end
endmodule
